// [hdl/mcs_pkg.sv]
// Shared constants and types for the module control and status block
package mcs_pkg;

   // Core clock
   localparam int unsigned MCS_CLK_NS = 10;

   // Condition flags: lanes 0..3 are receive loss of signal, the rest are other alarms
   localparam int unsigned MCS_FLAG_W = 8;
   localparam int unsigned MCS_LOS_LSB = 0;
   localparam int unsigned MCS_LOS_W = 4;

   // Printed latencies and limits, in their own units
   localparam int unsigned MCS_T_INIT_MS = 2000;
   localparam int unsigned MCS_T_RST_MIN_US = 2;
   localparam int unsigned MCS_T_LP_US = 100;
   localparam int unsigned MCS_T_SEL_US = 100;
   localparam int unsigned MCS_T_INT_ON_MS = 200;
   localparam int unsigned MCS_T_INT_OFF_US = 500;
   localparam int unsigned MCS_T_LOS_MS = 100;
   localparam int unsigned MCS_T_MASK_MS = 100;
   localparam int unsigned MCS_T_PDN_ON_MS = 100;
   localparam int unsigned MCS_T_PDN_OFF_MS = 300;
   // Wait for the third falling serial clock edge before a committed write is applied anyway
   localparam int unsigned MCS_T_EDGE_WAIT_US = 100;

   // Longest times round down, least times round up
   localparam longint unsigned MCS_INIT_CYC =
      (64'(MCS_T_INIT_MS) * 64'd1000000) / 64'(MCS_CLK_NS);
   localparam int unsigned MCS_RST_MIN_CYC =
      (MCS_T_RST_MIN_US * 1000 + MCS_CLK_NS - 1) / MCS_CLK_NS;
   localparam int unsigned MCS_EDGE_WAIT_CYC = (MCS_T_EDGE_WAIT_US * 1000) / MCS_CLK_NS;

   // Reset values, and the all-flags clear mask
   localparam logic [MCS_FLAG_W-1:0] MCS_FLAG_RST = 8'h00;
   localparam logic [MCS_FLAG_W-1:0] MCS_MASK_RST = 8'h00;
   localparam logic [MCS_FLAG_W-1:0] MCS_FLAG_ALL = 8'hFF;

   // Status byte that carries the data-not-ready bit
   localparam int unsigned MCS_STATUS_BYTE = 2;
   localparam int unsigned MCS_DNR_BIT = 0;

   typedef enum logic [0:0] {
      MCS_ST_INIT,
      MCS_ST_RUN
   } mcs_state_t;

   // Commands committed by the serial engine at the stop condition
   typedef struct packed {
      logic flag_rd;
      logic mask_wr;
      logic pdown_wr;
      logic [MCS_FLAG_W-1:0] mask_data;
      logic pdown_data;
   } mcs_cmd_t;

   // Status presented back to the serial engine for reading
   typedef struct packed {
      logic [MCS_FLAG_W-1:0] flags;
      logic [MCS_FLAG_W-1:0] mask;
      logic data_not_ready;
      logic pdown;
   } mcs_stat_t;

endpackage : mcs_pkg

// [hdl/mcs_sync.sv]
// Two flip-flop level synchroniser
module mcs_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;

endmodule : mcs_sync

// [hdl/mcs_ctrl.sv]
// Control, status and interrupt timing of a pluggable module, seen from the module
module mcs_ctrl
   import mcs_pkg::*;
#(
   parameter longint unsigned INIT_CYC = MCS_INIT_CYC,
   parameter int unsigned EDGE_WAIT_CYC = MCS_EDGE_WAIT_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_clk,
   input wire logic module_reset_n,
   input wire logic low_power_in,
   input wire logic bus_select_n,
   input wire logic [MCS_FLAG_W-1:0] cond_in,
   input wire mcs_cmd_t cmd_in,
   output logic irq_out_n,
   output logic presence_out_n,
   output logic bus_enable,
   output logic low_power_out,
   output mcs_stat_t stat_out
);

   // Pin inputs brought into the core domain
   logic rst_pin_s;
   logic lp_s;
   logic sel_n_s;
   logic [MCS_FLAG_W-1:0] cond_s;
   logic ack_s;

   // Reset pin idles high, so no false reset pulse follows power-up
   mcs_sync #(.W(1), .RST_VAL(1'b1)) u_sync_rst (
      .clk(clk),
      .rstn(rstn),
      .d(module_reset_n),
      .q(rst_pin_s)
   );

   mcs_sync #(.W(1), .RST_VAL(1'b0)) u_sync_lp (
      .clk(clk),
      .rstn(rstn),
      .d(low_power_in),
      .q(lp_s)
   );

   mcs_sync #(.W(1), .RST_VAL(1'b1)) u_sync_sel (
      .clk(clk),
      .rstn(rstn),
      .d(bus_select_n),
      .q(sel_n_s)
   );

   mcs_sync #(.W(MCS_FLAG_W), .RST_VAL(MCS_FLAG_RST)) u_sync_cond (
      .clk(clk),
      .rstn(rstn),
      .d(cond_in),
      .q(cond_s)
   );

   // Link domain: echoes the request toggle on serial clock falling edges.
   // The echo marks the third falling edge after the stop that committed the write.
   // Three falls pass before the echo; the first two only settle the toggle.
   logic req_tgl_ff;
   logic lk_meta_ff;
   logic lk_sync_ff;
   logic lk_ack_ff;

   always_ff @(negedge scl_clk or negedge rstn) begin
      if (!rstn) begin
         lk_meta_ff <= 1'b0;
         lk_sync_ff <= 1'b0;
         lk_ack_ff <= 1'b0;
      end else begin
         lk_meta_ff <= req_tgl_ff;
         lk_sync_ff <= lk_meta_ff;
         lk_ack_ff <= lk_sync_ff;
      end
   end

   mcs_sync #(.W(1), .RST_VAL(1'b0)) u_sync_ack (
      .clk(clk),
      .rstn(rstn),
      .d(lk_ack_ff),
      .q(ack_s)
   );

   // Core state
   mcs_state_t state_ff, nxt_state;
   // Wide enough for the full two-second default at the core clock
   logic [63:0] init_cnt_ff, nxt_init_cnt;
   logic [31:0] rst_cnt_ff, nxt_rst_cnt;
   logic dnr_ff, nxt_dnr;
   logic ready_irq_ff, nxt_ready_irq;
   logic [MCS_FLAG_W-1:0] flag_ff, nxt_flag;
   logic [MCS_FLAG_W-1:0] mask_ff, nxt_mask;
   logic [MCS_FLAG_W-1:0] cond_prev_ff, nxt_cond_prev;
   logic pdown_ff, nxt_pdown;
   logic pend_ff, nxt_pend;
   mcs_cmd_t pend_cmd_ff, nxt_pend_cmd;
   logic nxt_req_tgl;
   logic [31:0] wait_cnt_ff, nxt_wait_cnt;
   logic irq_n_ff, nxt_irq_n;
   logic bus_en_ff, nxt_bus_en;
   logic lp_out_ff, nxt_lp_out;
   logic pres_n_ff;

   logic cmd_any;
   logic apply;
   logic rst_hit;
   logic [MCS_FLAG_W-1:0] rise;
   logic [MCS_FLAG_W-1:0] clr;

   // Merge a later command into one still waiting for its serial edge
   function automatic mcs_cmd_t merge_cmd(input mcs_cmd_t old_c, input mcs_cmd_t new_c);
      mcs_cmd_t m;
      m = old_c;
      m.flag_rd = old_c.flag_rd | new_c.flag_rd;
      if (new_c.mask_wr) begin
         m.mask_wr = 1'b1;
         m.mask_data = new_c.mask_data;
      end
      if (new_c.pdown_wr) begin
         m.pdown_wr = 1'b1;
         m.pdown_data = new_c.pdown_data;
      end
      return m;
   endfunction : merge_cmd

   always_comb begin
      nxt_state = state_ff;
      nxt_init_cnt = init_cnt_ff;
      nxt_rst_cnt = rst_cnt_ff;
      nxt_dnr = dnr_ff;
      nxt_ready_irq = ready_irq_ff;
      nxt_flag = flag_ff;
      nxt_mask = mask_ff;
      nxt_cond_prev = cond_s;
      nxt_pdown = pdown_ff;
      nxt_pend = pend_ff;
      nxt_pend_cmd = pend_cmd_ff;
      nxt_req_tgl = req_tgl_ff;
      nxt_wait_cnt = wait_cnt_ff;
      clr = '0;

      // Short glitches on the reset pin are ignored
      if (!rst_pin_s) begin
         if (rst_cnt_ff < MCS_RST_MIN_CYC) begin
            nxt_rst_cnt = rst_cnt_ff + 32'h1;
         end
      end else begin
         nxt_rst_cnt = '0;
      end
      rst_hit = !rst_pin_s && (rst_cnt_ff >= MCS_RST_MIN_CYC);

      // Committed writes wait for the echo of the third falling serial edge, or time out if the bus clock parks
      cmd_any = cmd_in.flag_rd | cmd_in.mask_wr | cmd_in.pdown_wr;
      apply = pend_ff && ((ack_s == req_tgl_ff) || (wait_cnt_ff == EDGE_WAIT_CYC - 1));
      if (pend_ff && !apply) begin
         nxt_wait_cnt = wait_cnt_ff + 32'h1;
      end
      if (apply) begin
         nxt_pend = 1'b0;
         if (pend_cmd_ff.flag_rd) begin
            clr = MCS_FLAG_ALL;
         end
         if (pend_cmd_ff.mask_wr) begin
            nxt_mask = pend_cmd_ff.mask_data;
         end
         if (pend_cmd_ff.pdown_wr) begin
            nxt_pdown = pend_cmd_ff.pdown_data;
         end
      end
      if (cmd_any && state_ff == MCS_ST_RUN) begin
         if (pend_ff && !apply) begin
            nxt_pend_cmd = merge_cmd(pend_cmd_ff, cmd_in);
         end else begin
            nxt_pend = 1'b1;
            nxt_pend_cmd = cmd_in;
            // After a timed-out wait the echo lags; reuse the outstanding toggle then
            if (ack_s == req_tgl_ff) begin
               nxt_req_tgl = !req_tgl_ff;
            end
            nxt_wait_cnt = '0;
         end
      end

      // New conditions latch; a set in the clearing cycle is kept
      rise = cond_s & ~cond_prev_ff;
      nxt_flag = (flag_ff & ~clr) | rise;
      nxt_ready_irq = (ready_irq_ff & ~clr[MCS_DNR_BIT]);

      case (state_ff)
         MCS_ST_INIT: begin
            nxt_flag = MCS_FLAG_RST;
            nxt_ready_irq = 1'b0;
            if (init_cnt_ff >= INIT_CYC - 1) begin
               nxt_state = MCS_ST_RUN;
               nxt_dnr = 1'b0;
               nxt_ready_irq = 1'b1;
            end else begin
               nxt_init_cnt = init_cnt_ff + 64'h1;
            end
         end
         MCS_ST_RUN: begin
            nxt_state = MCS_ST_RUN;
         end
         default: begin
            nxt_state = MCS_ST_INIT;
         end
      endcase

      // A recognised reset pulse restarts initialisation from scratch
      // Presence stays shown; the module is still plugged in
      if (rst_hit) begin
         nxt_state = MCS_ST_INIT;
         nxt_init_cnt = '0;
         nxt_dnr = 1'b1;
         nxt_ready_irq = 1'b0;
         nxt_flag = MCS_FLAG_RST;
         nxt_mask = MCS_MASK_RST;
         nxt_pdown = 1'b0;
         nxt_pend = 1'b0;
      end

      // Interrupt follows unmasked flags and the data-ready event
      nxt_irq_n = !((|(nxt_flag & ~nxt_mask)) || nxt_ready_irq);
      // Bus answers only once ready and while selected
      nxt_bus_en = (nxt_state == MCS_ST_RUN) && !sel_n_s;
      nxt_lp_out = lp_s || nxt_pdown;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= MCS_ST_INIT;
         init_cnt_ff <= '0;
         rst_cnt_ff <= '0;
         dnr_ff <= 1'b1;
         ready_irq_ff <= 1'b0;
         flag_ff <= MCS_FLAG_RST;
         mask_ff <= MCS_MASK_RST;
         cond_prev_ff <= MCS_FLAG_RST;
         pdown_ff <= 1'b0;
         pend_ff <= 1'b0;
         pend_cmd_ff <= '0;
         req_tgl_ff <= 1'b0;
         wait_cnt_ff <= '0;
         irq_n_ff <= 1'b1;
         bus_en_ff <= 1'b0;
         lp_out_ff <= 1'b0;
         pres_n_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         init_cnt_ff <= nxt_init_cnt;
         rst_cnt_ff <= nxt_rst_cnt;
         dnr_ff <= nxt_dnr;
         ready_irq_ff <= nxt_ready_irq;
         flag_ff <= nxt_flag;
         mask_ff <= nxt_mask;
         cond_prev_ff <= nxt_cond_prev;
         pdown_ff <= nxt_pdown;
         pend_ff <= nxt_pend;
         pend_cmd_ff <= nxt_pend_cmd;
         req_tgl_ff <= nxt_req_tgl;
         wait_cnt_ff <= nxt_wait_cnt;
         irq_n_ff <= nxt_irq_n;
         bus_en_ff <= nxt_bus_en;
         lp_out_ff <= nxt_lp_out;
         // Presence is shown from the first clock after power-up
         pres_n_ff <= 1'b0;
      end
   end

   assign irq_out_n = irq_n_ff;
   assign presence_out_n = pres_n_ff;
   assign bus_enable = bus_en_ff;
   assign low_power_out = lp_out_ff;
   assign stat_out.flags = flag_ff;
   assign stat_out.mask = mask_ff;
   assign stat_out.data_not_ready = dnr_ff;
   assign stat_out.pdown = pdown_ff;

endmodule : mcs_ctrl

// [tb/mcs_ctrl_assertions.sv]
// Concurrent checks on the ports of the module control and status block
module mcs_ctrl_assertions
   import mcs_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_clk,
   input wire logic module_reset_n,
   input wire logic low_power_in,
   input wire logic bus_select_n,
   input wire logic [MCS_FLAG_W-1:0] cond_in,
   input wire mcs_cmd_t cmd_in,
   input wire logic irq_out_n,
   input wire logic presence_out_n,
   input wire logic bus_enable,
   input wire logic low_power_out,
   input wire mcs_stat_t stat_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_los_flag_set: assert property ($rose(cond_in[0]) && !stat_out.data_not_ready |-> ##3 stat_out.flags[0]) else $error("loss flag not set");
   a_alarm_flag_set: assert property ($rose(cond_in[7]) && !stat_out.data_not_ready |-> ##3 stat_out.flags[7]) else $error("alarm flag not set");
   a_irq_follows_flag: assert property (|(stat_out.flags & ~stat_out.mask) |-> !irq_out_n) else $error("interrupt not driven");
   a_irq_release_clean: assert property ($rose(irq_out_n) |-> ((stat_out.flags & ~stat_out.mask) == 8'h00)) else $error("interrupt released early");
   a_init_quiet: assert property (stat_out.data_not_ready |-> irq_out_n && !bus_enable) else $error("active during init");
   a_ready_irq: assert property ($fell(stat_out.data_not_ready) |-> ##[0:1] !irq_out_n) else $error("no readiness interrupt");
   a_select_on: assert property (!bus_select_n [*4] ##0 !stat_out.data_not_ready |-> bus_enable) else $error("bus not enabled");
   a_select_off: assert property (bus_select_n [*4] |=> !bus_enable) else $error("bus not disabled");
   a_lowpwr_on: assert property ((low_power_in && module_reset_n) [*6] |=> low_power_out) else $error("low power not entered");
   a_lowpwr_off: assert property ((!low_power_in && !stat_out.pdown) [*6] |-> !low_power_out) else $error("low power stuck");

   c_ready: cover property ($fell(stat_out.data_not_ready));
   c_los_irq: cover property (stat_out.flags[0] && !irq_out_n);
   c_pdown: cover property ($rose(stat_out.pdown));
endmodule : mcs_ctrl_assertions

bind mcs_ctrl mcs_ctrl_assertions mcs_ctrl_assertions_inst (.clk(clk), .rstn(rstn),
   .scl_clk(scl_clk), .module_reset_n(module_reset_n), .low_power_in(low_power_in),
   .bus_select_n(bus_select_n), .cond_in(cond_in), .cmd_in(cmd_in), .irq_out_n(irq_out_n),
   .presence_out_n(presence_out_n), .bus_enable(bus_enable), .low_power_out(low_power_out),
   .stat_out(stat_out));

// [tb/mcs_host.sv]
// Host controller model: control pins, serial clock and committed commands
module mcs_host
   import mcs_pkg::*;
(
   input wire logic clk,
   output logic scl_clk,
   output logic module_reset_n,
   output logic low_power_in,
   output logic bus_select_n,
   output mcs_cmd_t cmd_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl_clk = 1'b1;
      module_reset_n = 1'b1;
      low_power_in = 1'b0;
      bus_select_n = 1'b0;
      cmd_in = '0;
   end
   // Serial clock parks high between transfers; falls follow the stop condition
   task automatic send(input mcs_cmd_t c, input bit scl_on);
      @(posedge clk) #1 cmd_in = c;
      @(posedge clk) #1 cmd_in = '0;
      #7;
      if (scl_on) repeat (8) begin
         #32 scl_clk = 1'b0;
         #32 scl_clk = 1'b1;
      end
   endtask : send
   // A pulse shorter than the minimum width is meant to be ignored
   task automatic pulse_reset(input int n);
      @(posedge clk) #1 module_reset_n = 1'b0;
      repeat (n) @(posedge clk);
      #1 module_reset_n = 1'b1;
   endtask : pulse_reset
   task automatic pins(input logic lp, input logic sel_n);
      @(posedge clk) #1 low_power_in = lp;
      bus_select_n = sel_n;
   endtask : pins
endmodule : mcs_host

// [tb/mcs_ctrl_tb.sv]
// Self-checking testbench for the module control and status block
module mcs_ctrl_tb;
   import mcs_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam longint unsigned INIT = 50;
   localparam int unsigned EW = 20;
   localparam mcs_cmd_t RD = '{flag_rd: 1'b1, default: '0};
   logic clk = 1'b0;
   logic rstn;
   logic [MCS_FLAG_W-1:0] cond_in;
   logic scl_clk, module_reset_n, low_power_in, bus_select_n;
   mcs_cmd_t cmd_in;
   logic irq_out_n, presence_out_n, bus_enable, low_power_out;
   mcs_stat_t stat_out;
   int bad_count = 0;
   int n_compared = 0;

   always #5 clk = ~clk;

   mcs_host mcs_host_inst (.clk(clk), .scl_clk(scl_clk), .module_reset_n(module_reset_n),
      .low_power_in(low_power_in), .bus_select_n(bus_select_n), .cmd_in(cmd_in));
   mcs_ctrl #(.INIT_CYC(INIT), .EDGE_WAIT_CYC(EW)) mcs_ctrl_inst (.clk(clk), .rstn(rstn),
      .scl_clk(scl_clk), .module_reset_n(module_reset_n), .low_power_in(low_power_in),
      .bus_select_n(bus_select_n), .cond_in(cond_in), .cmd_in(cmd_in), .irq_out_n(irq_out_n),
      .presence_out_n(presence_out_n), .bus_enable(bus_enable), .low_power_out(low_power_out),
      .stat_out(stat_out));

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc

   task automatic t_init();
      int n = 0;
      while (stat_out.data_not_ready !== 1'b0 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      wait_cyc(2);
      check("ready_in_time", 8'h01, 8'(n <= INIT + 8));
      check("ready_irq", 8'h00, 8'(irq_out_n));
      check("bus_enable", 8'h01, 8'(bus_enable));
      check("presence", 8'h00, 8'(presence_out_n));
      mcs_host_inst.send(RD, 1'b1);
      wait_cyc(10);
      check("irq_after_read", 8'h01, 8'(irq_out_n));
   endtask : t_init

   task automatic t_cond();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) #1 cond_in[i] = 1'b1;
         wait_cyc(5);
         check("flags", 8'h01 << i, stat_out.flags);
         check("irq_on", 8'h00, 8'(irq_out_n));
         cond_in[i] = 1'b0;
         mcs_host_inst.send(RD, 1'b1);
         wait_cyc(10);
         check("flags_cleared", 8'h00, stat_out.flags);
         check("irq_off", 8'h01, 8'(irq_out_n));
      end
   endtask : t_cond

   task automatic t_mask();
      mcs_host_inst.send('{mask_wr: 1'b1, mask_data: 8'hFF, default: '0}, 1'b1);
      wait_cyc(10);
      cond_in[5] = 1'b1;
      wait_cyc(6);
      check("masked_flag", 8'h20, stat_out.flags);
      check("masked_irq", 8'h01, 8'(irq_out_n));
      mcs_host_inst.send('{mask_wr: 1'b1, mask_data: 8'h00, default: '0}, 1'b1);
      wait_cyc(10);
      check("unmasked_irq", 8'h00, 8'(irq_out_n));
      cond_in[5] = 1'b0;
      mcs_host_inst.send(RD, 1'b1);
      wait_cyc(10);
      check("irq_clear", 8'h01, 8'(irq_out_n));
   endtask : t_mask

   task automatic t_pins();
      mcs_host_inst.pins(1'b0, 1'b1);
      wait_cyc(6);
      check("deselect", 8'h00, 8'(bus_enable));
      mcs_host_inst.pins(1'b1, 1'b0);
      wait_cyc(6);
      check("select", 8'h01, 8'(bus_enable));
      check("lp_on", 8'h01, 8'(low_power_out));
      mcs_host_inst.pins(1'b0, 1'b0);
      // Parked serial clock: the write must still land after the fallback wait
      mcs_host_inst.send('{pdown_wr: 1'b1, pdown_data: 1'b1, default: '0}, 1'b0);
      wait_cyc(EW + 10);
      check("pdown_on", 8'h01, 8'(low_power_out));
      mcs_host_inst.send('{pdown_wr: 1'b1, pdown_data: 1'b0, default: '0}, 1'b1);
      wait_cyc(10);
      check("pdown_off", 8'h00, 8'(low_power_out));
   endtask : t_pins

   task automatic t_mreset();
      mcs_host_inst.pulse_reset(100);
      wait_cyc(5);
      check("short_reset", 8'h00, 8'(stat_out.data_not_ready));
      mcs_host_inst.pulse_reset(250);
      wait_cyc(1);
      check("long_reset", 8'h01, 8'(stat_out.data_not_ready));
      t_init();
   endtask : t_mreset

   initial begin
      rstn = 1'b0;
      cond_in = '0;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      t_init();
      t_cond();
      t_mask();
      t_pins();
      t_mreset();
      tally_and_finish();
   end

   initial begin
      #100us;
      bad_count++;
      tally_and_finish();
   end
endmodule : mcs_ctrl_tb
